// ### logic/srh_map.svh
// Selector codes, reset values and bit positions of the status reporting hierarchy.
// Assumes inclusion by the package and by every design module; it holds definitions only.
`ifndef SRH_MAP_SVH
`define SRH_MAP_SVH
`define SRH_GRP_OPER   2'h0
`define SRH_GRP_QUES   2'h1
`define SRH_GRP_STD    2'h2
`define SRH_GRP_TOP    2'h3
`define SRH_PART_LIVE  3'h0
`define SRH_PART_RISE  3'h1
`define SRH_PART_FALL  3'h2
`define SRH_PART_LATCH 3'h3
`define SRH_PART_MASK  3'h4
`define SRH_RISE_RESET 16'h7FFF
`define SRH_FALL_RESET 16'h0000
`define SRH_MASK_RESET 16'h0000
`define SRH_PART_VALID 16'h7FFF
`define SRH_STD_RESET  8'h00
`define SRH_SRE_RESET  8'h00
`define SRH_SRE_USED   8'hBF
`define SRH_STB_ERRQ   2
`define SRH_STB_QUES   3
`define SRH_STB_MAV    4
`define SRH_STB_ESB    5
`define SRH_STB_MSS    6
`define SRH_STB_OPER   7
`endif

// ### logic/srh_pkg.sv
// Types shared by the status reporting hierarchy.
// Assumes the map header sits on the include path.
package srh_pkg;
`include "srh_map.svh"
   // Which register group a command addresses.
   typedef enum logic [1:0] {
      SRH_OPER = `SRH_GRP_OPER,
      SRH_QUES = `SRH_GRP_QUES,
      SRH_STD  = `SRH_GRP_STD,
      SRH_TOP  = `SRH_GRP_TOP
   } srh_grp_e;
   // Which part of the group a command addresses.
   typedef enum logic [2:0] {
      SRH_LIVE  = `SRH_PART_LIVE,
      SRH_RISE  = `SRH_PART_RISE,
      SRH_FALL  = `SRH_PART_FALL,
      SRH_LATCH = `SRH_PART_LATCH,
      SRH_MASK  = `SRH_PART_MASK
   } srh_part_e;
   // One command from the controller link.
   typedef struct packed {
      logic        write;
      srh_grp_e    grp;
      srh_part_e   part;
      logic [15:0] wdata;
   } srh_cmd_s;
   // The five parts of one detailed status register.
   typedef struct packed {
      logic [15:0] live;
      logic [15:0] rise;
      logic [15:0] fall;
      logic [15:0] latch;
      logic [15:0] mask;
   } srh_parts_s;
endpackage : srh_pkg

// ### logic/srh_status_reg.sv
// One detailed status register: live, rising filter, falling filter, latched events, mask.
// Assumes live_in is synchronous to sys_clk and clr_events is a one-cycle read pulse.
`timescale 1ns/1ps
`include "srh_map.svh"
module srh_status_reg (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic [14:0]         live_in,
   input  wire logic                wr_en,
   input  wire srh_pkg::srh_part_e  wr_part,
   input  wire logic [15:0]         wr_data,
   input  wire logic                clr_events,
   output srh_pkg::srh_parts_s      parts,
   output logic                     summary
);
   logic [15:0] live_reg;   // Last sampled status.
   logic [15:0] rise_reg;   // Rising filter.
   logic [15:0] fall_reg;   // Falling filter.
   logic [15:0] latch_reg;  // Latched events.
   logic [15:0] mask_reg;   // Event mask.
   logic [15:0] live_next;  // Status about to be sampled.
   logic [15:0] rise_hit;   // Passed rising transitions.
   logic [15:0] fall_hit;   // Passed falling transitions.
   logic [15:0] hit;        // All passed transitions.

   // Bit 15 is tied low, so every part reads as a non-negative number.
   assign live_next = {1'b0, live_in};
   assign rise_hit  = live_next & ~live_reg & rise_reg;
   assign fall_hit  = ~live_next & live_reg & fall_reg;
   assign hit       = rise_hit | fall_hit;

   // The live part only samples status; no command path reaches it.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) live_reg <= 16'h0000;
      else live_reg <= live_next;
   end

   // Filters and mask are plain storage; reads never touch them.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rise_reg <= `SRH_RISE_RESET;
         fall_reg <= `SRH_FALL_RESET;
         mask_reg <= `SRH_MASK_RESET;
      end else if (wr_en) begin
         if (wr_part == srh_pkg::SRH_RISE) rise_reg <= wr_data & `SRH_PART_VALID;
         if (wr_part == srh_pkg::SRH_FALL) fall_reg <= wr_data & `SRH_PART_VALID;
         if (wr_part == srh_pkg::SRH_MASK) mask_reg <= wr_data & `SRH_PART_VALID;
      end
   end

   // Events stick until read; a transition in the clearing cycle wins over the clear.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) latch_reg <= 16'h0000;
      else latch_reg <= (clr_events ? 16'h0000 : latch_reg) | hit;
   end

   assign parts   = '{live: live_reg, rise: rise_reg, fall: fall_reg, latch: latch_reg, mask: mask_reg};
   assign summary = |(latch_reg & mask_reg);

   property p_rise_capture;
      @(posedge sys_clk) disable iff (!rst_n) (rise_hit != 16'h0000) |=> ((latch_reg & $past(rise_hit)) == $past(rise_hit));
   endproperty
   a_rise_capture: assert property (p_rise_capture) else $error("Passed rising transition not latched.");
   property p_fall_capture;
      @(posedge sys_clk) disable iff (!rst_n) (fall_hit != 16'h0000) |=> ((latch_reg & $past(fall_hit)) == $past(fall_hit));
   endproperty
   a_fall_capture: assert property (p_fall_capture) else $error("Passed falling transition not latched.");
   property p_only_filtered;
      @(posedge sys_clk) disable iff (!rst_n) 1'b1 |=> ((latch_reg & ~($past(latch_reg) | $past(hit))) == 16'h0000);
   endproperty
   a_only_filtered: assert property (p_only_filtered) else $error("Event set without a passed transition.");
   property p_clear_keeps_new;
      @(posedge sys_clk) disable iff (!rst_n) clr_events |=> (latch_reg == $past(hit));
   endproperty
   a_clear_keeps_new: assert property (p_clear_keeps_new) else $error("Clearing read lost or kept wrong events.");
   property p_top_bit_zero;
      @(posedge sys_clk) disable iff (!rst_n) ##1 !(latch_reg[15] | rise_reg[15] | fall_reg[15] | mask_reg[15]);
   endproperty
   a_top_bit_zero: assert property (p_top_bit_zero) else $error("Bit 15 of a part is set.");
endmodule : srh_status_reg

// ### logic/srh_srq_gen.sv
// Service request edge detector behind the status byte.
// Assumes req_vec is the status byte already masked by the service request mask.
`timescale 1ns/1ps
`include "srh_map.svh"
module srh_srq_gen (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] req_vec,
   input  wire logic       poll_clear,
   output logic            srq_pulse,
   output logic            srq_pending
);
   logic [7:0] req_prev;  // Masked status byte one cycle ago.
   logic       new_req;   // Some enabled bit has just risen.

   assign new_req = |(req_vec & ~req_prev);

   // Previous vector for edge detection.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) req_prev <= 8'h00;
      else req_prev <= req_vec;
   end

   // One-cycle request pulse plus a pending flag that a serial poll clears; a new request wins.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         srq_pulse   <= 1'b0;
         srq_pending <= 1'b0;
      end else begin
         srq_pulse   <= new_req;
         srq_pending <= (poll_clear ? 1'b0 : srq_pending) | new_req;
      end
   end

   property p_srq_on_rise;
      @(posedge sys_clk) disable iff (!rst_n) new_req |=> srq_pulse ##1 (srq_pending || $past(poll_clear));
   endproperty
   a_srq_on_rise: assert property (p_srq_on_rise) else $error("Enabled rise gave no service request.");
   property p_no_srq_idle;
      @(posedge sys_clk) disable iff (!rst_n) (req_vec == 8'h00) |=> !srq_pulse;
   endproperty
   a_no_srq_idle: assert property (p_no_srq_idle) else $error("Service request without enabled bit.");
endmodule : srh_srq_gen

// ### logic/srh_top.sv
// Status reporting hierarchy: operation and questionable registers, the standard
// event pair, the status byte with its service request mask, and the command port.
// Assumes commands and status inputs are synchronous to sys_clk; one command per cycle.
// Answers are registered on the taking edge itself; writes give no answer.
`timescale 1ns/1ps
`include "srh_map.svh"
module srh_top (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [14:0]      oper_live_in,
   input  wire logic [14:0]      ques_live_in,
   input  wire logic [7:0]       std_event_in,
   input  wire logic             err_queue_nonempty,
   input  wire logic             out_buf_has_msg,
   input  wire logic             cmd_valid,
   input  wire srh_pkg::srh_cmd_s cmd,
   input  wire logic             poll_req,
   output logic                  resp_valid,
   output logic [15:0]           resp_data,
   output logic [7:0]            top_status_byte,
   output logic                  srq_pulse,
   output logic                  srq_pending
);
   // Command decode.
   logic        cmd_take;      // Command accepted this cycle.
   logic        wr_take;       // Accepted write.
   logic        rd_take;       // Accepted read.
   logic        oper_wr;       // Write aimed at the operation register.
   logic        ques_wr;       // Write aimed at the questionable register.
   logic        oper_clr;      // Clearing read of operation events.
   logic        ques_clr;      // Clearing read of questionable events.
   logic        std_clr;       // Clearing read of the standard event register.
   logic        ese_wr;        // Write to the standard event mask.
   logic        sre_wr;        // Write to the service request mask.

   // Register state owned here.
   logic [7:0]  standard_event_register;  // Sticky standard events.
   logic [7:0]  standard_event_mask;      // Mask of standard events.
   logic [7:0]  sre_mask_reg;             // Service request mask.
   logic [7:0]  stb_body;                 // Status byte bits other than bit 6.
   logic [7:0]  stb_next;                 // Full status byte before the register.
   logic [7:0]  req_vec;                  // Status bits that may raise a request.
   logic        esb_next;                 // Standard event summary.

   // Outputs of the two detailed registers.
   srh_pkg::srh_parts_s oper_parts;       // Operation register parts.
   srh_pkg::srh_parts_s ques_parts;       // Questionable register parts.
   logic        oper_sum;                 // Operation summary.
   logic        ques_sum;                 // Questionable summary.

   // Rebuilt summaries, read only by the checks at the end.
   logic        oper_sum_chk;             // Operation summary rebuilt from its parts.
   logic        ques_sum_chk;             // Questionable summary rebuilt from its parts.

   // A poll takes the port; a command offered in the same cycle is dropped,
   // because the answer path carries only one word per cycle.
   assign cmd_take = cmd_valid && !poll_req;
   assign wr_take  = cmd_take && cmd.write;
   assign rd_take  = cmd_take && !cmd.write;

   // Group decode for writes and clearing reads. Writes aimed at the live or
   // latched part match no storage below, so both stay read-only from the
   // link without any extra refusal logic.
   assign oper_wr  = wr_take && (cmd.grp == srh_pkg::SRH_OPER);
   assign ques_wr  = wr_take && (cmd.grp == srh_pkg::SRH_QUES);
   assign oper_clr = rd_take && (cmd.grp == srh_pkg::SRH_OPER) && (cmd.part == srh_pkg::SRH_LATCH);
   assign ques_clr = rd_take && (cmd.grp == srh_pkg::SRH_QUES) && (cmd.part == srh_pkg::SRH_LATCH);
   assign std_clr  = rd_take && (cmd.grp == srh_pkg::SRH_STD) && (cmd.part == srh_pkg::SRH_LATCH);
   assign ese_wr   = wr_take && (cmd.grp == srh_pkg::SRH_STD) && (cmd.part == srh_pkg::SRH_MASK);
   assign sre_wr   = wr_take && (cmd.grp == srh_pkg::SRH_TOP) && (cmd.part == srh_pkg::SRH_MASK);

   // Operation detailed register.
   srh_status_reg u_oper (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .live_in    (oper_live_in),
      .wr_en      (oper_wr),
      .wr_part    (cmd.part),
      .wr_data    (cmd.wdata),
      .clr_events (oper_clr),
      .parts      (oper_parts),
      .summary    (oper_sum)
   );

   // Questionable detailed register.
   srh_status_reg u_ques (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .live_in    (ques_live_in),
      .wr_en      (ques_wr),
      .wr_part    (cmd.part),
      .wr_data    (cmd.wdata),
      .clr_events (ques_clr),
      .parts      (ques_parts),
      .summary    (ques_sum)
   );

   // Standard event register: events stick until read, and a new event
   // arriving in the clearing cycle is kept.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) standard_event_register <= `SRH_STD_RESET;
      else standard_event_register <= (std_clr ? 8'h00 : standard_event_register) | std_event_in;
   end

   // Standard event mask, written by command, unchanged by reads.
   // Its reset value keeps the summary bit quiet until a mask is written.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) standard_event_mask <= `SRH_STD_RESET;
      else if (ese_wr) standard_event_mask <= cmd.wdata[7:0];
   end

   // Service request mask keeps bit 6 as written; the request logic ignores it.
   // Keeping the bit lets a read-back return exactly what was written.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) sre_mask_reg <= `SRH_SRE_RESET;
      else if (sre_wr) sre_mask_reg <= cmd.wdata[7:0];
   end

   // The summary of the standard pair is a level, so it rises with the first
   // enabled event and falls once that event is read away.
   assign esb_next = |(standard_event_register & standard_event_mask);

   // Status byte bits other than bit 6; bits 0 and 1 are unused and read zero.
   // The error queue flag arrives as a level from outside this block.
   always_comb begin
      stb_body                = 8'h00;
      stb_body[`SRH_STB_ERRQ] = err_queue_nonempty;
      stb_body[`SRH_STB_QUES] = ques_sum;
      stb_body[`SRH_STB_MAV]  = out_buf_has_msg;
      stb_body[`SRH_STB_ESB]  = esb_next;
      stb_body[`SRH_STB_OPER] = oper_sum;
   end

   // Only enabled bits outside bit 6 may request service.
   // Bit 6 is cut here so that the summary cannot feed back into itself.
   assign req_vec = stb_body & sre_mask_reg & `SRH_SRE_USED;

   // Bit 6 summarises every other enabled bit.
   always_comb begin
      stb_next               = stb_body;
      stb_next[`SRH_STB_MSS] = |req_vec;
   end

   // The status byte is registered so the pin view is glitch free; it lags
   // the lower registers by one cycle.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) top_status_byte <= 8'h00;
      else top_status_byte <= stb_next;
   end

   // Rising edges of the masked status byte raise the service request.
   // The poll strobe also clears the pending flag; a request that rises in
   // the poll cycle wins, so it cannot be lost between two polls.
   srh_srq_gen u_srq (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .req_vec     (req_vec),
      .poll_clear  (poll_req),
      .srq_pulse   (srq_pulse),
      .srq_pending (srq_pending)
   );

   // Picks the word a read returns; unknown selectors read zero.
   // Eight-bit registers answer in the low byte with the upper byte zero.
   function automatic logic [15:0] read_mux(
      input srh_pkg::srh_grp_e   grp,
      input srh_pkg::srh_part_e  part,
      input srh_pkg::srh_parts_s op,
      input srh_pkg::srh_parts_s qu,
      input logic [7:0]          stb,
      input logic [7:0]          service_request_mask,
      input logic [7:0]          ser,
      input logic [7:0]          sem
   );
      srh_pkg::srh_parts_s sel;
      logic [15:0]         word;
      sel  = (grp == srh_pkg::SRH_QUES) ? qu : op;
      word = 16'h0000;
      case (grp)
         srh_pkg::SRH_OPER, srh_pkg::SRH_QUES: begin
            case (part)
               srh_pkg::SRH_LIVE:  word = sel.live;
               srh_pkg::SRH_RISE:  word = sel.rise;
               srh_pkg::SRH_FALL:  word = sel.fall;
               srh_pkg::SRH_LATCH: word = sel.latch;
               srh_pkg::SRH_MASK:  word = sel.mask;
               default:            word = 16'h0000;
            endcase
         end
         srh_pkg::SRH_STD: begin
            case (part)
               srh_pkg::SRH_LATCH: word = {8'h00, ser};
               srh_pkg::SRH_MASK:  word = {8'h00, sem};
               default:            word = 16'h0000;
            endcase
         end
         srh_pkg::SRH_TOP: begin
            case (part)
               srh_pkg::SRH_LIVE:  word = {8'h00, stb};
               srh_pkg::SRH_MASK:  word = {8'h00, service_request_mask};
               default:            word = 16'h0000;
            endcase
         end
         default: word = 16'h0000;
      endcase
      return word;
   endfunction : read_mux

   // Answers: one cycle after a read or a poll. A clearing read returns the
   // contents from before the clear, since the clear lands on the same edge.
   // A poll wins the port, so its answer is never mixed with a read's.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         resp_valid <= 1'b0;
         resp_data  <= 16'h0000;
      end else begin
         resp_valid <= rd_take || poll_req;
         if (poll_req) begin
            resp_data <= {8'h00, top_status_byte};
         end else if (rd_take) begin
            resp_data <= read_mux(cmd.grp, cmd.part, oper_parts, ques_parts, top_status_byte,
                                  sre_mask_reg, standard_event_register, standard_event_mask);
         end
      end
   end

   // Checks on the status byte and the answer path. Each summary is rebuilt
   // from the exported parts, so a broken summary wire cannot vouch for itself.
   assign oper_sum_chk = |(oper_parts.latch & oper_parts.mask);
   assign ques_sum_chk = |(ques_parts.latch & ques_parts.mask);

   // An enabled standard event reaches the summary bit two edges later.
   sequence s_enabled_std_event;
      ((std_event_in & standard_event_mask) != 8'h00) && !ese_wr;
   endsequence
   property p_esb_sets;
      @(posedge sys_clk) disable iff (!rst_n) s_enabled_std_event |=> ##1 top_status_byte[`SRH_STB_ESB];
   endproperty
   a_esb_sets: assert property (p_esb_sets) else $error("Enabled standard event did not set the summary bit.");

   // The message bit lags the buffer flag by exactly one register stage.
   property p_mav_follows;
      @(posedge sys_clk) disable iff (!rst_n) ##1 (top_status_byte[`SRH_STB_MAV] == $past(out_buf_has_msg));
   endproperty
   a_mav_follows: assert property (p_mav_follows) else $error("Message bit does not follow the buffer.");

   // Both detailed summaries land in the status byte one edge later.
   property p_oper_summary;
      @(posedge sys_clk) disable iff (!rst_n)
         ##1 (top_status_byte[`SRH_STB_OPER] == $past(oper_sum_chk));
   endproperty
   a_oper_summary: assert property (p_oper_summary) else $error("Operation summary bit wrong.");

   property p_ques_summary;
      @(posedge sys_clk) disable iff (!rst_n)
         ##1 (top_status_byte[`SRH_STB_QUES] == $past(ques_sum_chk));
   endproperty
   a_ques_summary: assert property (p_ques_summary) else $error("Questionable summary bit wrong.");

   // Bit 6 stays low while no enabled bit outside it is set.
   property p_mss_ignores_bit6;
      @(posedge sys_clk) disable iff (!rst_n)
         ((stb_body & sre_mask_reg & `SRH_SRE_USED) == 8'h00) |=> !top_status_byte[`SRH_STB_MSS];
   endproperty
   a_mss_ignores_bit6: assert property (p_mss_ignores_bit6) else $error("Bit 6 set with no enabled bit.");

   // A poll answers with the status byte as it stood at the poll edge.
   property p_poll_answer;
      @(posedge sys_clk) disable iff (!rst_n)
         poll_req |=> (resp_valid && (resp_data == {8'h00, $past(top_status_byte)}));
   endproperty
   a_poll_answer: assert property (p_poll_answer) else $error("Serial poll answer wrong.");

   // Every accepted read answers on the next edge.
   property p_read_answer;
      @(posedge sys_clk) disable iff (!rst_n) rd_take |=> resp_valid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("Accepted read gave no answer.");

   // Nothing but a read or a poll raises the answer strobe.
   property p_no_stray_answer;
      @(posedge sys_clk) disable iff (!rst_n) (!rd_take && !poll_req) |=> !resp_valid;
   endproperty
   a_no_stray_answer: assert property (p_no_stray_answer) else $error("Answer strobe without a request.");

   // Standard events stick until a clearing read, and one arriving with
   // the clear survives it.
   property p_std_sticky;
      @(posedge sys_clk) disable iff (!rst_n)
         !std_clr |=> ((~standard_event_register & $past(standard_event_register)) == 8'h00);
   endproperty
   a_std_sticky: assert property (p_std_sticky) else $error("Standard event lost without a read.");

   property p_std_clear_keeps_new;
      @(posedge sys_clk) disable iff (!rst_n) std_clr |=> (standard_event_register == $past(std_event_in));
   endproperty
   a_std_clear_keeps_new: assert property (p_std_clear_keeps_new) else $error("Standard clear kept wrong events.");

   // A read never alters either mask.
   property p_read_keeps_masks;
      @(posedge sys_clk) disable iff (!rst_n) rd_take |=> ($stable(standard_event_mask) && $stable(sre_mask_reg));
   endproperty
   a_read_keeps_masks: assert property (p_read_keeps_masks) else $error("A read changed a mask.");
endmodule : srh_top

// ### verification/srh_ctrl_model.sv
// Remote controller model: issues register commands and serial polls to the block.
// Assumes the answer word is registered on the taking edge and is valid just after it.
`timescale 1ns/1ps
module srh_ctrl_model (
   input  wire logic         sys_clk,
   input  wire logic         resp_valid,
   input  wire logic [15:0]  resp_data,
   output srh_pkg::srh_cmd_s cmd,
   output logic              cmd_valid,
   output logic              poll_req
);
   // The link starts idle so nothing is taken before the first transfer.
   initial begin
      cmd_valid = 1'b0;
      poll_req  = 1'b0;
      cmd       = '0;
   end
   // One command or one poll; the request is held for exactly the taking edge.
   task automatic xfer(input logic is_poll, input logic wr, input srh_pkg::srh_grp_e g,
                       input srh_pkg::srh_part_e p, input logic [15:0] wd, output logic [15:0] rd);
      @(posedge sys_clk);
      #1;
      poll_req  = is_poll;
      cmd_valid = !is_poll;
      cmd       = '{wr, g, p, wd};
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'b0;
      poll_req  = 1'b0;
      // The data word is inverted when idle, so a stale word is never read as fresh.
      cmd.wdata = ~wd;
      rd        = (resp_valid === 1'b1) ? resp_data : 16'hXXXX;
   endtask : xfer
endmodule : srh_ctrl_model

// ### verification/tb_status_reporting_hierarchy.sv
// Self-checking bench of the status reporting hierarchy top.
// Assumes the controller model in its own file and the design package compiled first.
`timescale 1ns/1ps
module tb_status_reporting_hierarchy;
   logic              sys_clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [14:0]       oper_live_in = '0;
   logic [14:0]       ques_live_in = '0;
   logic [7:0]        std_event_in = '0;
   logic              err_queue_nonempty = 1'b0;
   logic              out_buf_has_msg = 1'b0;
   logic              cmd_valid;
   logic              poll_req;
   srh_pkg::srh_cmd_s cmd;
   logic              resp_valid;
   logic [15:0]       resp_data;
   logic [7:0]        top_status_byte;
   logic              srq_pulse;
   logic              srq_pending;
   int                error_cnt = 0;
   int                n_checks = 0;
   int                srq_cnt = 0;
   int                cycles = 0;
   logic [15:0]       got;
   srh_top srh_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .oper_live_in(oper_live_in),
      .ques_live_in(ques_live_in), .std_event_in(std_event_in), .err_queue_nonempty(err_queue_nonempty),
      .out_buf_has_msg(out_buf_has_msg), .cmd_valid(cmd_valid), .cmd(cmd), .poll_req(poll_req),
      .resp_valid(resp_valid), .resp_data(resp_data), .top_status_byte(top_status_byte),
      .srq_pulse(srq_pulse), .srq_pending(srq_pending));
   srh_ctrl_model srh_ctrl_model_i (.sys_clk(sys_clk), .resp_valid(resp_valid), .resp_data(resp_data),
      .cmd(cmd), .cmd_valid(cmd_valid), .poll_req(poll_req));
   // A 4 ns clock, as the block runs at 250 MHz.
   always #2 sys_clk = ~sys_clk;
   // Requests last one cycle, so they are counted here rather than polled by tasks.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (srq_pulse === 1'b1) begin
         srq_cnt <= srq_cnt + 1;
      end
      if (cycles == 3000) begin
         error_cnt = error_cnt + 1;
         end_sim();
      end
   end
   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   // Compares one answer word or status value against the expected value.
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks = n_checks + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Waits n edges and lands just after the last one, where inputs are changed.
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic rd(input int g, input int p, output logic [15:0] d);
      srh_ctrl_model_i.xfer(1'b0, 1'b0, srh_pkg::srh_grp_e'(g), srh_pkg::srh_part_e'(p), 16'h0000, d);
   endtask : rd
   task automatic wr(input int g, input int p, input logic [15:0] wd);
      logic [15:0] d;
      srh_ctrl_model_i.xfer(1'b0, 1'b1, srh_pkg::srh_grp_e'(g), srh_pkg::srh_part_e'(p), wd, d);
   endtask : wr
   // Reset values, then filter and mask write, read-back and repeated reads.
   task automatic t_parts();
      for (int g = 0; g < 2; g++) begin
         rd(g, 1, got); chk(got, 16'h7FFF);
         rd(g, 2, got); chk(got, 16'h0000);
         rd(g, 4, got); chk(got, 16'h0000);
         wr(g, 1, 16'hFFF0); rd(g, 1, got); chk(got, 16'h7FF0);
         wr(g, 2, 16'h1234); rd(g, 2, got); rd(g, 2, got); chk(got, 16'h1234);
         wr(g, 4, 16'h80A5); rd(g, 4, got); rd(g, 4, got); chk(got, 16'h00A5);
         wr(g, 1, 16'h7FFF); wr(g, 2, 16'h0000); wr(g, 4, 16'h0000);
      end
      rd(3, 4, got); chk(got, 16'h0000);
   endtask : t_parts
   // Live part, rising and falling capture, a one-cycle pulse, read-clear.
   task automatic t_events();
      oper_live_in = 15'h0A5A;
      cyc(3);
      wr(0, 0, 16'h0000); rd(0, 0, got); rd(0, 0, got); chk(got, 16'h0A5A);
      rd(0, 3, got); chk(got, 16'h0A5A);
      rd(0, 3, got); chk(got, 16'h0000);
      wr(0, 3, 16'h7FFF); rd(0, 3, got); chk(got, 16'h0000);
      wr(0, 2, 16'h0002);
      oper_live_in = 15'h0004;
      cyc(1);
      oper_live_in = 15'h0000;
      cyc(3);
      rd(0, 3, got); chk(got, 16'h0006);
   endtask : t_events
   // Summary into the status byte, mask bit 6 ignored, request on enable, poll.
   task automatic t_srq();
      wr(3, 4, 16'h0040);
      wr(1, 4, 16'h0010);
      ques_live_in = 15'h0010;
      cyc(1);
      ques_live_in = 15'h0000;
      cyc(4);
      chk({8'h00, top_status_byte}, 16'h0008);
      chk(16'(srq_cnt), 16'h0000);
      wr(3, 4, 16'h0048);
      cyc(3);
      chk(16'(srq_cnt), 16'h0001);
      chk({15'h0000, srq_pending}, 16'h0001);
      chk({8'h00, top_status_byte}, 16'h0048);
      srh_ctrl_model_i.xfer(1'b1, 1'b0, srh_pkg::SRH_TOP, srh_pkg::SRH_LIVE, 16'h0000, got);
      chk(got, 16'h0048);
      chk({15'h0000, srq_pending}, 16'h0000);
      rd(1, 3, got); chk(got, 16'h0010);
      cyc(3);
      chk({8'h00, top_status_byte}, 16'h0000);
   endtask : t_srq
   // Standard event summary, message available and error queue bits.
   task automatic t_std();
      wr(2, 4, 16'h0001);
      std_event_in = 8'h01;
      out_buf_has_msg = 1'b1;
      err_queue_nonempty = 1'b1;
      cyc(1);
      std_event_in = 8'h00;
      cyc(3);
      chk({8'h00, top_status_byte}, 16'h0034);
      rd(3, 0, got); chk(got, 16'h0034);
      rd(2, 3, got); chk(got, 16'h0001);
      rd(2, 4, got); chk(got, 16'h0001);
      out_buf_has_msg = 1'b0;
      err_queue_nonempty = 1'b0;
      cyc(3);
      chk({8'h00, top_status_byte}, 16'h0000);
   endtask : t_std
   // Main sequence: reset for four cycles, then every scenario in turn.
   initial begin
      repeat (4) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      t_parts();
      t_events();
      t_srq();
      t_std();
      end_sim();
   end
endmodule : tb_status_reporting_hierarchy
